// ==== design/clear_decrement_complement_exec.sv ====
// execution block for accumulator clear, watchdog restart,
// file decrement and file complement, with a classic Wishbone slave
// assumes one 100 MHz clock; each instruction word is written to the
// instruction register and executes in the cycle its write is acked
//
// How it works
// - accumulator-clear opcode zeroes accumulator and sets result null flag
// - watchdog-restart opcode zeroes watchdog count and its prescaler
// - watchdog restart sets timeout and sleep flags, no other status
// - decrement opcode subtracts one; d=0 to accumulator, d=1 to file
// - invert opcode produces bitwise complement of the selected file
// - invert result goes to accumulator or file per d, other untouched
//
// The Wishbone interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "cdc_exec_map.svh"
module clear_decrement_complement_exec #(
  parameter int PRESCALE_W = 8,
  parameter int COUNT_W = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // core state
  output logic [7:0] accValue,
  output logic resultNullFlag,
  output logic timeoutFlagN,
  output logic sleepFlagN,
  output logic [COUNT_W-1:0] watchdogCount
);
  import cdc_exec_pkg::*;

  exec_if ex ();
  exec_decode u_decode (.ex(ex));

  logic [7:0] fileMem [0:127];
  logic [13:0] lastInstr;
  logic [PRESCALE_W-1:0] prescale;

  // bus decode; access happens once, on the acked edge
  wire access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire doWrite = access & wb_we_i & wb_sel_i[0];
  wire [9:0] wordAdr = {wb_adr_i[9:2], 2'b00};
  wire hitFile = wb_adr_i[`FILE_BASE_BIT];
  wire hitInstr = ~hitFile & (wordAdr == `OFS_INSTR);
  wire hitAcc = ~hitFile & (wordAdr == `OFS_ACC);
  wire hitStatus = ~hitFile & (wordAdr == `OFS_STATUS);
  wire hitWdog = ~hitFile & (wordAdr == `OFS_WDOG);
  wire [6:0] fileIdx = wb_adr_i[8:2];

  // execute the word being written; upper byte lane must be enabled too
  wire execute = doWrite & wb_sel_i[1] & hitInstr;
  assign ex.instr = wb_dat_i[13:0];
  assign ex.operand = fileMem[wb_dat_i[6:0]];

  wire kick = execute & (ex.op == OP_KICK);
  wire writesResult = execute & (ex.op == OP_MINUS_ONE | ex.op == OP_INVERT);
  wire zeroAcc = execute & (ex.op == OP_ZERO_ACC);
  wire fileFromExec = execute & ex.toFile;
  wire fileFromBus = doWrite & hitFile;
  wire [6:0] fileWrIdx = fileFromExec ? wb_dat_i[6:0] : fileIdx;
  wire [7:0] fileWrData = fileFromExec ? ex.result : wb_dat_i[7:0];

  wire [7:0] statusWord = {5'h00,
                           timeoutFlagN,
                           sleepFlagN,
                           resultNullFlag};
  wire [31:0] readData =
    hitFile ? {24'h000000, fileMem[fileIdx]} :
    hitInstr ? {18'h00000, lastInstr} :
    hitAcc ? {24'h000000, accValue} :
    hitStatus ? {24'h000000, statusWord} :
    hitWdog ? {{(32 - COUNT_W - PRESCALE_W){1'b0}}, prescale, watchdogCount} :
    32'h00000000;

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= access;
      wb_dat_o <= access ? readData : 32'h00000000;
    end
  end

  // file registers have no reset, like a real register file
  always_ff @(posedge sys_clk) begin
    if (fileFromExec | fileFromBus) begin
      fileMem[fileWrIdx] <= fileWrData;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lastInstr <= 14'h0000;
      accValue <= `ACC_RST;
    end else begin
      if (execute) begin
        lastInstr <= wb_dat_i[13:0];
      end
      if (execute & ex.toAcc) begin
        accValue <= ex.result;
      end else if (doWrite & hitAcc) begin
        accValue <= wb_dat_i[7:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      resultNullFlag <= `ST_NULL_RST;
      timeoutFlagN <= `ST_TIMEOUT_RST;
      sleepFlagN <= `ST_SLEEP_RST;
    end else if (zeroAcc) begin
      resultNullFlag <= 1'b1;
    end else if (writesResult) begin
      resultNullFlag <= ex.result == 8'h00;
    end else if (kick) begin
      timeoutFlagN <= 1'b1;
      sleepFlagN <= 1'b1;
    end else if (doWrite & hitStatus) begin
      resultNullFlag <= wb_dat_i[`ST_NULL_BIT];
      sleepFlagN <= wb_dat_i[`ST_SLEEP_BIT];
      timeoutFlagN <= wb_dat_i[`ST_TIMEOUT_BIT];
    end
  end

  // stand-in for the watchdog's own timebase so the restart is visible
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prescale <= '0;
      watchdogCount <= '0;
    end else if (kick) begin
      prescale <= '0;
      watchdogCount <= '0;
    end else begin
      prescale <= prescale + 1'b1;
      if (&prescale) begin
        watchdogCount <= watchdogCount + 1'b1;
      end
    end
  end
endmodule : clear_decrement_complement_exec
`default_nettype wire

// ==== design/cdc_exec_map.svh ====
// constants for the clear / decrement / complement execution block
// assumes byte addressing on a 32-bit classic Wishbone bus
`ifndef CDC_EXEC_MAP_SVH
`define CDC_EXEC_MAP_SVH

// register byte offsets
`define OFS_INSTR 10'h000
`define OFS_ACC 10'h004
`define OFS_STATUS 10'h008
`define OFS_WDOG 10'h00c
// file registers occupy 0x200..0x3fc, one byte per word
`define FILE_BASE_BIT 9

// status field positions and reset values
`define ST_NULL_BIT 0
`define ST_SLEEP_BIT 1
`define ST_TIMEOUT_BIT 2
`define ST_NULL_RST 1'b0
`define ST_SLEEP_RST 1'b1
`define ST_TIMEOUT_RST 1'b1
`define ACC_RST 8'h00

// instruction word layout and encodings
`define INSTR_W 14
`define DEST_BIT 7
`define ZERO_ACC_PAT 7'h02
`define KICK_WORD 14'h0064
`define MINUS_ONE_PAT 6'h03
`define INVERT_PAT 6'h09

`endif

// ==== design/cdc_exec_pkg.sv ====
// types shared by the execution block and its decoder
// no assumptions beyond a SystemVerilog-2012 tool
package cdc_exec_pkg;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_ZERO_ACC,
    OP_KICK,
    OP_MINUS_ONE,
    OP_INVERT
  } op_t;
endpackage : cdc_exec_pkg

// ==== design/exec_if.sv ====
// carrier between the execution core and its decoder
// assumes both ends sit in one clock domain
`timescale 1ns/100ps
`default_nettype none
interface exec_if;
  import cdc_exec_pkg::*;
  logic [13:0] instr;
  logic [7:0] operand;
  op_t op;
  logic [7:0] result;
  logic toAcc;
  logic toFile;
  modport alu (input instr, input operand,
               output op, output result, output toAcc, output toFile);
  modport core (output instr, output operand,
                input op, input result, input toAcc, input toFile);
endinterface : exec_if
`default_nettype wire

// ==== design/exec_decode.sv ====
// combinational decoder and arithmetic for the four instructions
// assumes the operand is the file register named by instr[6:0]
`timescale 1ns/100ps
`default_nettype none
`include "cdc_exec_map.svh"
module exec_decode (
  exec_if.alu ex
);
  import cdc_exec_pkg::*;

  wire isZeroAcc = ex.instr[13:7] == `ZERO_ACC_PAT;
  wire isKick = ex.instr == `KICK_WORD;
  wire isMinus = ex.instr[13:8] == `MINUS_ONE_PAT;
  wire isInvert = ex.instr[13:8] == `INVERT_PAT;
  wire dest = ex.instr[`DEST_BIT];

  assign ex.op = isZeroAcc ? OP_ZERO_ACC :
                 isKick ? OP_KICK :
                 isMinus ? OP_MINUS_ONE :
                 isInvert ? OP_INVERT : OP_NONE;
  // clear yields zero; low seven bits are don't-care
  assign ex.result = isMinus ? ex.operand - 8'h01 :
                     isInvert ? ~ex.operand :
                     8'h00;
  // d=0 goes to the accumulator, d=1 back to the file
  assign ex.toAcc = isZeroAcc | ((isMinus | isInvert) & ~dest);
  assign ex.toFile = (isMinus | isInvert) & dest;
endmodule : exec_decode
`default_nettype wire

// ==== verif/wb_master_model.sv ====
// classic wishbone master standing in for the fetch path
// assumes a slave that acks every taken request
`timescale 1ns/100ps
`default_nettype none
module wb_master_model (
  // clock and answer
  input wire logic clk,
  input wire logic ack,
  input wire logic [31:0] rdat,
  // request
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [9:0] adr,
  output logic [3:0] sel,
  output logic [31:0] wdat
);
  initial begin
    {cyc, stb, we, adr, sel, wdat} = '0;
  end
  task automatic xfer(input logic w, input logic [9:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hf, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb, we} <= 3'b000;
    // released data must not keep looking valid
    wdat <= ~d;
    @(posedge clk);
  endtask : xfer
endmodule : wb_master_model
`default_nettype wire

// ==== verif/cdc_exec_assertions.sv ====
// port checks for the execution block
// assumes binding into its top module
`timescale 1ns/100ps
`default_nettype none
module cdc_exec_assertions #(parameter int COUNT_W = 8) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic [7:0] accValue,
  input wire logic resultNullFlag,
  input wire logic timeoutFlagN,
  input wire logic sleepFlagN,
  input wire logic [COUNT_W-1:0] watchdogCount
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire [13:0] w = wb_dat_i[13:0];
  wire tk = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o & (&wb_sel_i[1:0])
            & (wb_adr_i[9:2] == 8'h00);
  wire kick = tk && w == 14'h0064;
  wire dec = tk && w[13:8] == 6'h03;
  wire inv = tk && w[13:8] == 6'h09;
  zero_acc_a: assert property (tk && w[13:7] == 7'h02 |=>
    accValue == 8'h00 && resultNullFlag) else $error("acc clear");
  kick_count_a: assert property (kick |=> watchdogCount == '0)
    else $error("kick count");
  kick_flags_a: assert property (kick |=> timeoutFlagN && sleepFlagN
    && resultNullFlag == $past(resultNullFlag)) else $error("kick flags");
  dec_file_a: assert property (dec && w[7] |=> $stable(accValue))
    else $error("dec to file moved acc");
  inv_file_a: assert property (inv && w[7] |=> $stable(accValue))
    else $error("inv to file moved acc");
  rmw_null_a: assert property ((dec || inv) && !w[7] |=>
    resultNullFlag == (accValue == 8'h00)) else $error("null flag");
  rmw_other_a: assert property (dec || inv |=>
    $stable({timeoutFlagN, sleepFlagN})) else $error("other status");
endmodule : cdc_exec_assertions
bind clear_decrement_complement_exec cdc_exec_assertions #(.COUNT_W(COUNT_W))
  u_cdc_exec_assertions (.sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .accValue, .resultNullFlag,
  .timeoutFlagN, .sleepFlagN, .watchdogCount);
`default_nettype wire

// ==== verif/testbench.sv ====
// self-checking bench for the execution block
// assumes the master model runs one request at a time
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic sysClk = 1'b0;
  logic rstN = 1'b0;
  logic cyc, stb, we, ack, nul, toN, slN;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] datW, datR, rd;
  logic [7:0] acc, wdc;
  int miscompares = 0;
  int cmpCount = 0;
  initial forever #5 sysClk = ~sysClk;
  wb_master_model u_wb_master_model (.clk(sysClk), .ack(ack), .rdat(datR),
    .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .wdat(datW));
  clear_decrement_complement_exec u_clear_decrement_complement_exec (
    .sys_clk(sysClk), .rst_n(rstN), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW),
    .wb_dat_o(datR), .wb_ack_o(ack), .accValue(acc), .resultNullFlag(nul),
    .timeoutFlagN(toN), .sleepFlagN(slN), .watchdogCount(wdc));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmpCount++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task tally_and_finish;
    $display("compares %0d mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  task wr(input logic [9:0] a, input logic [31:0] d);
    u_wb_master_model.xfer(1'b1, a, d, rd);
  endtask : wr
  task x(input logic [13:0] i);
    wr(10'h000, {18'h0, i});
  endtask : x
  task rc(input string n, input logic [9:0] a, input logic [31:0] e);
    u_wb_master_model.xfer(1'b0, a, 32'h0, rd);
    chk(n, e, rd);
  endtask : rc
  initial begin
    #200us;
    miscompares++;
    tally_and_finish;
  end
  initial begin
    repeat (12) @(posedge sysClk);
    rstN <= 1'b1;
    @(posedge sysClk);
    wr(10'h214, 32'h01);
    x(14'h0385);
    chk("null", 32'h1, nul);
    rc("file5", 10'h214, 32'h00);
    x(14'h0305);
    chk("acc", 32'hff, acc);
    chk("null", 32'h0, nul);
    rc("file5", 10'h214, 32'h00);
    wr(10'h3fc, 32'h13);
    x(14'h097f);
    chk("acc", {24'h0, ~8'h13}, acc);
    rc("file127", 10'h3fc, 32'h13);
    wr(10'h004, 32'h5a);
    x(14'h09ff);
    chk("acc", 32'h5a, acc);
    rc("file127", 10'h3fc, {24'h0, ~8'h13});
    wr(10'h3fc, 32'hff);
    x(14'h09ff);
    chk("null", 32'h1, nul);
    wr(10'h008, 32'h0);
    // opcode 00 0001 0 with the don't-care bits all set
    x(14'h017f);
    chk("acc", 32'h0, acc);
    rc("status", 10'h008, 32'h1);
    wr(10'h008, 32'h0);
    // let the count leave zero so the restart is visible
    repeat (600) @(posedge sysClk);
    x(14'h0064);
    chk("wdog", 32'h0, wdc);
    chk("timeout", 32'h1, toN);
    chk("sleep", 32'h1, slN);
    rc("status", 10'h008, 32'h6);
    u_wb_master_model.xfer(1'b0, 10'h00c, 32'h0, rd);
    chk("wdogreg", 32'h0, rd[7:0]);
    chk("presc", 32'h1, rd[15:8] < 8'h10);
    rc("instr", 10'h000, 32'h64);
    tally_and_finish;
  end
endmodule : testbench
`default_nettype wire
